/* src/ubd_descriptor.sv */
`timescale 1ns/100ps
`include "ubd_regs.svh"
// Descriptor engine with the packet memory. Software side on a word-per-slot
// port; engine side takes token requests and moves IN bytes out through a FIFO.
module ubd_descriptor
  import ubd_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        swSel,
  input  wire logic        swWrite,
  input  wire logic [10:0] swAddr,
  input  wire logic [15:0] swWdata,
  output logic      [15:0] swRdata,
  output logic             swReady,
  input  wire logic [15:0] descriptorTableBase,
  input  wire ubd_req_t    req,
  input  wire logic        reqValid,
  output logic             reqReady,
  input  wire logic        rxValid,
  output logic             rxReady,
  input  wire ubd_byte_t   rxByte,
  output logic             txValid,
  input  wire logic        txReady,
  output ubd_byte_t        txByte,
  output logic             doneValid,
  output logic             doneOk,
  output logic      [9:0]  doneCount,
  output logic             busy
);
  localparam int AW = $clog2(`UBD_MEM_WORDS);

  logic [15:0]       mem [`UBD_MEM_WORDS];
  ubd_state_t        state;
  ubd_req_t          cur;
  logic [15:0]       startPtr;
  logic [15:0]       lenWord;
  logic [10:0]       allocBytes;
  logic [10:0]       byteIdx;
  logic [15:0]       wordBuf;
  logic              overflow;
  logic              rxEnded;
  logic [AW-1:0]     engAddr;
  logic              engWe;
  logic [15:0]       engWdata;
  logic [15:0]       engRdata;
  logic              isIn;
  logic [10:0]       txLen;
  logic              fifoInValid;
  logic              fifoInReady;
  ubd_byte_t         fifoInData;
  logic              swWe;
  logic [AW-1:0]     swWord;

  // Engine-side local word address of one descriptor entry
  function automatic logic [AW-1:0] entryAddr(input logic [15:0] base, input logic [3:0] ep, input logic [2:0] ent);
    logic [15:0] byteAddr;
    byteAddr = {base[15:3], 3'b000} + {9'h000, ep, 3'b000} + {12'h000, ent, 1'b0};
    return byteAddr[AW:1];
  endfunction

  // Count times 2 bytes, or count plus one times 32 bytes
  function automatic logic [10:0] allocSize(input logic [15:0] w);
    logic [4:0] blocks;
    blocks = w[`UBD_BLOCKS_MSB:`UBD_BLOCKS_LSB];
    if (w[`UBD_UNIT_BIT]) begin
      return {1'b0, blocks, 5'h00} + 11'h020;
    end else begin
      return {5'h00, blocks, 1'b0};
    end
  endfunction

  assign isIn     = (cur.kind == UBD_TOK_IN);
  assign txLen    = {1'b0, lenWord[`UBD_LEN_MSB:0]};
  assign busy     = (state != UBD_IDLE);
  assign reqReady = (state == UBD_IDLE);
  // Software waits while the engine reads descriptors, writes back, sends, or stores an odd received byte
  assign swReady  = !(state == UBD_DESC0 || state == UBD_DESC1 || state == UBD_WBACK ||
                      (state == UBD_MOVE && (isIn || (rxValid && byteIdx[0]))));
  assign swWord   = swAddr[AW-1:0];
  // Bits 9:0 of the receive count entry are read-only to software
  assign swWe     = swSel && swWrite && swReady;

  always_comb begin
    engWe    = 1'b0;
    engWdata = wordBuf;
    engAddr  = '0;
    case (state)
      UBD_DESC0: engAddr = entryAddr(descriptorTableBase, cur.endpoint,
                                     isIn ? `UBD_ENTRY_TX_START : `UBD_ENTRY_RX_START);
      UBD_DESC1: engAddr = entryAddr(descriptorTableBase, cur.endpoint,
                                     isIn ? `UBD_ENTRY_TX_LEN : `UBD_ENTRY_RX_LEN);
      UBD_MOVE: begin
        engAddr = startPtr[AW:1] + AW'(byteIdx[10:1]);
        if (!isIn && rxValid && !overflow && byteIdx < allocBytes) begin
          engWe    = 1'b1;
          engWdata = byteIdx[0] ? {rxByte.data, wordBuf[7:0]} : {8'h00, rxByte.data};
        end
      end
      UBD_WBACK: begin
        engAddr  = entryAddr(descriptorTableBase, cur.endpoint, `UBD_ENTRY_RX_LEN);
        engWe    = 1'b1;
        engWdata = {lenWord[15:10], byteIdx[`UBD_LEN_MSB:0]};
      end
      default: engAddr = '0;
    endcase
  end

  assign engRdata = mem[engAddr];

  always_ff @(posedge clk_sys) begin
    if (engWe) begin
      mem[engAddr] <= engWdata;
    end else if (swWe) begin
      // Only receive length entries inside the table are guarded; buffer words are plain
      if (swWord[1:0] == 2'b11 && swWord >= descriptorTableBase[AW:1] &&
          {1'b0, swWord} < {1'b0, descriptorTableBase[AW:1]} + 10'h040) begin
        mem[swWord] <= {swWdata[15:10], mem[swWord][9:0]};
      end else begin
        mem[swWord] <= swWdata;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      swRdata <= 16'h0000;
    end else if (swSel && !swWrite && swReady) begin
      swRdata <= mem[swWord];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state <= UBD_IDLE;
    end else begin
      case (state)
        UBD_IDLE:  if (reqValid && req.kind != UBD_TOK_NONE) state <= UBD_DESC0;
        UBD_DESC0: state <= UBD_DESC1;
        UBD_DESC1: state <= UBD_MOVE;
        UBD_MOVE: begin
          if (isIn && byteIdx == txLen && !fifoInValid) begin
            state <= UBD_DONE;
          end else if (!isIn && rxValid && rxByte.last) begin
            state <= UBD_WBACK;
          end
        end
        UBD_WBACK: state <= UBD_DONE;
        UBD_DONE:  state <= UBD_IDLE;
        default:   state <= UBD_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cur        <= '0;
      startPtr   <= 16'h0000;
      lenWord    <= 16'h0000;
      allocBytes <= 11'h000;
      byteIdx    <= 11'h000;
      wordBuf    <= 16'h0000;
      overflow   <= 1'b0;
      rxEnded    <= 1'b0;
    end else begin
      case (state)
        UBD_IDLE: begin
          cur      <= req;
          byteIdx  <= 11'h000;
          overflow <= 1'b0;
          rxEnded  <= 1'b0;
        end
        UBD_DESC0: startPtr <= {engRdata[15:1], 1'b0};
        UBD_DESC1: begin
          lenWord    <= engRdata;
          allocBytes <= allocSize(engRdata);
        end
        UBD_MOVE: begin
          if (!isIn && rxValid) begin
            rxEnded <= rxByte.last;
            if (byteIdx >= allocBytes) begin
              overflow <= 1'b1;
            end else begin
              wordBuf <= engWdata;
            end
            if (byteIdx != 11'h7ff) begin
              byteIdx <= byteIdx + 11'h001;
            end
          end else if (isIn && fifoInValid && fifoInReady) begin
            byteIdx <= byteIdx + 11'h001;
          end
        end
        default: ;
      endcase
    end
  end

  // Reads are combinational, so each fetched byte is offered the same cycle
  assign fifoInValid     = (state == UBD_MOVE) && isIn && (byteIdx < txLen);
  assign fifoInData.data = byteIdx[0] ? engRdata[15:8] : engRdata[7:0];
  assign fifoInData.last = (byteIdx + 11'h001 == txLen);
  assign rxReady         = (state == UBD_MOVE) && !isIn;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      doneValid <= 1'b0;
      doneOk    <= 1'b0;
      doneCount <= 10'h000;
    end else begin
      doneValid <= (state == UBD_DONE);
      if (state == UBD_DONE) begin
        doneOk    <= isIn || !overflow;
        doneCount <= byteIdx[`UBD_LEN_MSB:0];
      end
    end
  end

  ubd_fifo #(
    .WIDTH ($bits(ubd_byte_t)),
    .DEPTH (`UBD_FIFO_DEPTH)
  ) txFifo (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .flush    (1'b0),
    .inValid  (fifoInValid),
    .inReady  (fifoInReady),
    .inData   (fifoInData),
    .outValid (txValid),
    .outReady (txReady),
    .outData  (txByte)
  );
endmodule

/* src/ubd_fifo.sv */
`timescale 1ns/100ps
module ubd_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  input  wire logic             flush,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      fill;
  logic             push;
  logic             pop;

  assign inReady  = (fill != (AW+1)'(DEPTH));
  assign outValid = (fill != '0);
  assign outData  = mem[rdPtr];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn || flush) begin
      wrPtr <= '0;
      rdPtr <= '0;
      fill  <= '0;
    end else begin
      if (push) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (pop) begin
        rdPtr <= rdPtr + 1'b1;
      end
      fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

/* src/ubd_pkg.sv */
package ubd_pkg;
  typedef enum logic [2:0] {
    UBD_IDLE  = 3'b000,
    UBD_DESC0 = 3'b001,
    UBD_DESC1 = 3'b011,
    UBD_MOVE  = 3'b010,
    UBD_WBACK = 3'b110,
    UBD_DONE  = 3'b111
  } ubd_state_t;

  typedef enum logic [1:0] {
    UBD_TOK_NONE  = 2'b00,
    UBD_TOK_IN    = 2'b01,
    UBD_TOK_OUT   = 2'b10,
    UBD_TOK_SETUP = 2'b11
  } ubd_token_t;

  typedef struct packed {
    ubd_token_t  kind;
    logic [3:0]  endpoint;
  } ubd_req_t;

  typedef struct packed {
    logic        last;
    logic [7:0]  data;
  } ubd_byte_t;
endpackage

/* src/ubd_regs.svh */
`ifndef UBD_REGS_SVH
`define UBD_REGS_SVH
`define UBD_MEM_WORDS      512
`define UBD_ENTRY_TX_START 3'd0
`define UBD_ENTRY_TX_LEN   3'd1
`define UBD_ENTRY_RX_START 3'd2
`define UBD_ENTRY_RX_LEN   3'd3
`define UBD_LEN_MSB        9
`define UBD_UNIT_BIT       15
`define UBD_BLOCKS_MSB     14
`define UBD_BLOCKS_LSB     10
`define UBD_APB_SHIFT      2
`define UBD_FIFO_DEPTH     32
`endif

/* test/ubd_descriptor_properties.sv */
`timescale 1ns/100ps
module ubd_checker
  import ubd_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic        swSel,
  input wire logic        swWrite,
  input wire logic        swReady,
  input wire logic [15:0] swRdata,
  input wire ubd_req_t    req,
  input wire logic        reqValid,
  input wire logic        reqReady,
  input wire logic        rxValid,
  input wire logic        rxReady,
  input wire logic        txValid,
  input wire logic        txReady,
  input wire ubd_byte_t   txByte,
  input wire logic        doneValid,
  input wire logic        doneOk,
  input wire logic [9:0]  doneCount,
  input wire logic        busy
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  ubd_token_t kind;
  logic [9:0] rxCnt;
  logic [9:0] txCnt;
  wire        taken = reqValid && reqReady && req.kind != UBD_TOK_NONE;
  always_ff @(posedge clk_sys) begin
    if (!rstn) kind <= UBD_TOK_NONE;
    else if (taken) kind <= req.kind;
  end
  always_ff @(posedge clk_sys) begin
    if (!rstn || taken) rxCnt <= '0;
    else if (rxValid && rxReady) rxCnt <= rxCnt + 10'h001;
  end
  // Counts bytes the host really took, not bytes queued
  always_ff @(posedge clk_sys) begin
    if (!rstn || taken) txCnt <= '0;
    else if (txValid && txReady) txCnt <= txCnt + 10'h001;
  end
  sequence reqTaken; taken; endsequence
  sequence doneSeen; doneValid; endsequence
  done_pulse_a: assert property (doneSeen |=> !doneValid) else $error("done held too long");
  idle_ready_a: assert property (reqReady != busy) else $error("ready and busy disagree");
  take_busy_a: assert property (reqTaken |=> busy) else $error("request did not start");
  done_bound_a: assert property (reqTaken |-> ##[4:1000] doneSeen) else $error("no done");
  rx_count_a: assert property (doneValid && doneOk && kind != UBD_TOK_IN |-> doneCount == rxCnt)
    else $error("rx count wrong");
  error_kind_a: assert property (doneValid && !doneOk |-> kind != UBD_TOK_IN) else $error("tx error");
  read_stands_a: assert property (!(swSel && swReady && !swWrite) |=> $stable(swRdata))
    else $error("read data moved");
  tx_total_a: assert property (txValid && txReady && txByte.last |=> ##[0:3] doneCount == txCnt)
    else $error("tx count wrong");
endmodule
bind ubd_descriptor ubd_checker ubd_checker_inst (.*);

/* test/ubd_host.sv */
`timescale 1ns/100ps
module ubd_host
  import ubd_pkg::*;
(
  input  wire logic      clk_sys,
  input  wire logic      reqReady,
  input  wire logic      rxReady,
  input  wire logic      txValid,
  input  wire ubd_byte_t txByte,
  output ubd_req_t       req,
  output logic           reqValid,
  output logic           rxValid,
  output ubd_byte_t      rxByte,
  output logic           txReady
);
  logic      slowTx = 1'b0;
  ubd_byte_t txSeen[$];
  initial begin
    req = '0;
    reqValid = 1'b0;
    rxValid = 1'b0;
    rxByte = '0;
    txReady = 1'b1;
  end
  // A slow host takes a byte only every other cycle
  always begin
    @(posedge clk_sys);
    #1 txReady = !slowTx || !txReady;
    #8 if (txValid && txReady) txSeen.push_back(txByte);
  end
  task automatic transact(input ubd_token_t k, input logic [3:0] ep, input int n, input logic [7:0] d0);
    logic ok;
    req = '{k, ep};
    reqValid = 1'b1;
    do begin #8 ok = reqReady; @(posedge clk_sys); #1; end while (!ok);
    reqValid = 1'b0;
    req = '{UBD_TOK_NONE, ~ep};
    for (int i = 0; i < n; i++) begin
      rxValid = 1'b1;
      rxByte = '{i == n - 1, d0 + 8'(i)};
      do begin #8 ok = rxReady; @(posedge clk_sys); #1; end while (!ok);
    end
    rxValid = 1'b0;
    rxByte = ~rxByte;
  endtask
endmodule

/* test/usb_buffer_descriptor_table_bench.sv */
`timescale 1ns/100ps
module usb_buffer_descriptor_table_bench
  import ubd_pkg::*;
;
  logic        clk_sys = 1'b0, rstn = 1'b0, swSel = 1'b0, swWrite = 1'b0;
  logic        swReady, reqReady, reqValid, rxReady, rxValid, txValid, txReady, doneValid, doneOk, busy;
  logic [10:0] swAddr = '0;
  logic [15:0] swWdata = '0, swRdata, got, descriptorTableBase = 16'h0000;
  logic [9:0]  doneCount;
  ubd_req_t    req;
  ubd_byte_t   rxByte, txByte;
  int          num_errors = 0, checks_done = 0;
  ubd_descriptor ubd_descriptor_inst (.*);
  ubd_host ubd_host_inst (.*);
  always #5 clk_sys = ~clk_sys;
  task automatic close_out;
    $display("Checks %0d, errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic access(input logic wr, input logic [10:0] a, input logic [15:0] d);
    logic ok;
    swSel = 1'b1;
    swWrite = wr;
    swAddr = a;
    swWdata = d;
    do begin #8 ok = swReady; @(posedge clk_sys); #1; end while (!ok);
    swSel = 1'b0;
    swWdata = ~d;
    got = swRdata;
    // Idle cycle so the next call never raises the strobe in this time step
    @(posedge clk_sys) #1;
  endtask
  task automatic rd(input logic [10:0] a, input logic [15:0] exp);
    access(1'b0, a, 16'h0000);
    check(got, exp);
  endtask
  task automatic run(input ubd_token_t k, input logic [3:0] ep, input int n);
    int t;
    ubd_host_inst.transact(k, ep, n, 8'h10);
    for (t = 0; t < 300 && doneValid !== 1'b1; t++) @(posedge clk_sys) #1;
    if (t == 300) begin
      num_errors++;
      close_out;
    end
    for (t = 0; t < 40 && txValid !== 1'b0; t++) @(posedge clk_sys) #1;
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    #1 rstn = 1'b1;
    access(1'b1, 11'h004, 16'h0040);
    access(1'b1, 11'h005, 16'hfc03);
    access(1'b1, 11'h020, 16'h2211);
    access(1'b1, 11'h021, 16'h4433);
    access(1'b1, 11'h00a, 16'h0080);
    access(1'b1, 11'h00b, 16'h0c00);
    access(1'b1, 11'h043, 16'h5a5a);
    access(1'b1, 11'h00e, 16'h00c0);
    access(1'b1, 11'h00f, 16'h8000);
    access(1'b1, 11'h070, 16'ha5a5);
    // Host stalls while the packet drains
    ubd_host_inst.slowTx = 1'b1;
    run(UBD_TOK_IN, 4'h1, 0);
    check({6'h00, doneCount}, 16'h0003);
    check(16'(ubd_host_inst.txSeen.size()), 16'h0003);
    foreach (ubd_host_inst.txSeen[i])
      check({7'h00, ubd_host_inst.txSeen[i]}, {7'h00, i == 2, 8'h11 * 8'(i + 1)});
    run(UBD_TOK_OUT, 4'h2, 4);
    check({15'h0000, doneOk}, 16'h0001);
    rd(11'h00b, 16'h0c04);
    rd(11'h040, 16'h1110);
    rd(11'h041, 16'h1312);
    access(1'b1, 11'h00b, 16'h0fff);
    rd(11'h00b, 16'h0c04);
    run(UBD_TOK_SETUP, 4'h2, 8);
    check({15'h0000, doneOk}, 16'h0000);
    rd(11'h042, 16'h1514);
    rd(11'h043, 16'h5a5a);
    run(UBD_TOK_OUT, 4'h3, 32);
    check({15'h0000, doneOk}, 16'h0001);
    rd(11'h06f, 16'h2f2e);
    run(UBD_TOK_SETUP, 4'h3, 33);
    check({15'h0000, doneOk}, 16'h0000);
    rd(11'h070, 16'ha5a5);
    close_out;
  end
  initial begin
    #100000;
    num_errors++;
    close_out;
  end
endmodule
